//--- hw/twd_top.sv
// unit-two watchdog: AHB-Lite registers, lock, interrupts, pulse out
`timescale 1ns/1ps
`default_nettype none
module twd_top #(
   parameter int BASE = twd_pkg::BASE_DIV
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic watchdog_pulse_internal_o,
   output logic irq_o
);
   import twd_pkg::*;

   // the whole front-end state in one record
   typedef struct packed {
      logic [REG_W-1:0] glob;
      logic [CNT_W-1:0] image;
      logic [REG_W-1:0] cmd;
      logic [IRQ_W-1:0] istat;
      logic [IRQ_W-1:0] imask;
      logic dp;
      logic dp_wr;
      logic [ADDR_LSB_W-1:0] dp_addr;
      logic ready;
      logic [31:0] rdata;
      logic irq;
      logic pulse;
      logic reload;
      logic cnt_wr;
      logic [CNT_W-1:0] cnt_wdata;
   } twd_top_type;

   twd_top_type s_ff, nxt_s;
   logic locked;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;
   logic [REG_W-1:0] glob_wr;

   twd_if u ();

   // register select, used by both the read and the write path
   function automatic logic [3:0] reg_sel(
      input logic [ADDR_LSB_W-1:0] a
   );
      logic [3:0] r;
      r = 4'hF;
      case (a)
         OFS_GLOBAL: begin
            r = 4'h0;
         end
         OFS_LOADST: begin
            r = 4'h1;
         end
         OFS_COUNT: begin
            r = 4'h2;
         end
         OFS_IMAGE: begin
            r = 4'h3;
         end
         OFS_CMD: begin
            r = 4'h4;
         end
         OFS_ISTAT: begin
            r = 4'h5;
         end
         OFS_IMASK: begin
            r = 4'h6;
         end
         OFS_STATUS: begin
            r = 4'h7;
         end
         default: begin
            r = 4'hF;
         end
      endcase
      return r;
   endfunction : reg_sel

   // read mux; unmapped words and reserved bits read as zero
   function automatic logic [31:0] read_word(
      input logic [3:0] sel,
      input twd_top_type st,
      input logic [CNT_W-1:0] cnt,
      input logic [2:0] stat
   );
      logic [31:0] d;
      d = 32'h0000_0000;
      case (sel)
         4'h0: begin
            d = 32'(st.glob);
         end
         4'h2: begin
            d = 32'(cnt);
         end
         4'h3: begin
            d = 32'(st.image);
         end
         4'h4: begin
            d = 32'(st.cmd);
         end
         4'h5: begin
            d = 32'(st.istat);
         end
         4'h6: begin
            d = 32'(st.imask);
         end
         4'h7: begin
            d = 32'(stat);
         end
         default: begin
            // load strobe bits are write-only, read as zero
            d = 32'h0000_0000;
         end
      endcase
      return d;
   endfunction : read_word

   // watchdog mode sticks from the first write that sets its bit
   assign locked = s_ff.glob[GB_WDOG];

   // in watchdog mode scale, start and watchdog bits are frozen;
   // without this software could simply stop the counter again
   always_comb begin
      glob_wr = hwdata_i[REG_W-1:0];
      if (locked) begin
         glob_wr[GB_WDOG] = 1'b1;
         glob_wr[GB_START] = s_ff.glob[GB_START];
         glob_wr[GB_SCALE] = s_ff.glob[GB_SCALE];
      end
   end

   // events that raise sticky interrupt bits
   assign irq_set[IRQ_UNDER] = u.underflow;
   assign irq_set[IRQ_RELOAD] = s_ff.reload;

   // write-one-to-clear mask from a data phase to the interrupt status word
   always_comb begin
      irq_clr = '0;
      if (s_ff.dp && s_ff.dp_wr &&
          reg_sel(s_ff.dp_addr) == 4'h5) begin
         irq_clr = hwdata_i[IRQ_W-1:0];
      end
   end

   // bus slave and register file
   always_comb begin
      nxt_s = s_ff;
      nxt_s.reload = 1'b0;
      nxt_s.cnt_wr = 1'b0;
      if (!s_ff.dp && hsel_i && htrans_i[HTRANS_BUSY_BIT] && hready_i) begin
         // address phase: capture, stretch the data phase one cycle
         nxt_s.dp = 1'b1;
         nxt_s.dp_wr = hwrite_i;
         nxt_s.dp_addr = haddr_i[ADDR_LSB_W-1:0];
         nxt_s.ready = 1'b0;
      end else if (s_ff.dp) begin
         // data phase: hwdata is stable now
         nxt_s.dp = 1'b0;
         nxt_s.ready = 1'b1;
         if (s_ff.dp_wr) begin
            case (reg_sel(s_ff.dp_addr))
               4'h0: begin
                  nxt_s.glob = glob_wr;
               end
               4'h1: begin
                  nxt_s.reload = hwdata_i[LS_UNIT2];
               end
               4'h2: begin
                  // counter preset is refused in watchdog mode
                  if (!locked) begin
                     nxt_s.cnt_wr = 1'b1;
                     nxt_s.cnt_wdata = hwdata_i[CNT_W-1:0];
                  end
               end
               4'h3: begin
                  if (!locked) begin
                     nxt_s.image = hwdata_i[CNT_W-1:0];
                  end
               end
               4'h4: begin
                  // stored for the other modes; never read by unit
                  if (!locked) begin
                     nxt_s.cmd = hwdata_i[REG_W-1:0];
                  end
               end
               4'h6: begin
                  nxt_s.imask = hwdata_i[IRQ_W-1:0];
               end
               default: begin
                  // status and holes: write ignored; interrupt status clears through irq_clr
                  nxt_s.dp_wr = 1'b0;
               end
            endcase
         end else begin
            nxt_s.rdata = read_word(reg_sel(s_ff.dp_addr), s_ff,
                                    u.count,
                                    {u.active, u.pulse, locked});
         end
      end
      // set beats clear when both land in one cycle
      nxt_s.istat = (s_ff.istat & ~irq_clr) | irq_set;
      nxt_s.irq = |(nxt_s.istat & nxt_s.imask);
      // registered copy so the pin is glitch free toward the array
      nxt_s.pulse = u.pulse;
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_ff <= '{glob: GLOBAL_RST, image: IMAGE_RST, cmd: CMD_RST,
                   istat: IRQ_RST, imask: IRQ_RST, ready: 1'b1,
                   default: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // the global mode bit is not consulted: watchdog runs in both
   assign u.run = s_ff.glob[GB_WDOG] & s_ff.glob[GB_START];
   // scale acts on the timer clock prescaler inside unit two
   assign u.scale = s_ff.glob[GB_SCALE];
   assign u.reload = s_ff.reload;
   assign u.cnt_wr = s_ff.cnt_wr;
   assign u.cnt_wdata = s_ff.cnt_wdata;
   assign u.image = s_ff.image;

   // the only counter/timer kept here is unit two
   twd_unit #(
      .BASE(BASE)
   ) unit_two (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .u(u)
   );

   // outputs straight from flops; hresp_o tied low
   assign hrdata_o = s_ff.rdata;
   assign hreadyout_o = s_ff.ready;
   assign hresp_o = 1'b0;
   assign watchdog_pulse_internal_o = s_ff.pulse;
   assign irq_o = s_ff.irq;
endmodule : twd_top
`default_nettype wire

//--- common/twd_pkg.sv
// constants and types shared by the unit-two watchdog block
package twd_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_GLOBAL = 8'h00;
   localparam logic [7:0] OFS_LOADST = 8'h04;
   localparam logic [7:0] OFS_COUNT = 8'h08;
   localparam logic [7:0] OFS_IMAGE = 8'h0C;
   localparam logic [7:0] OFS_CMD = 8'h10;
   localparam logic [7:0] OFS_ISTAT = 8'h14;
   localparam logic [7:0] OFS_IMASK = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam int ADDR_LSB_W = 8;
   // global command bits
   localparam int GB_SCALE = 0;
   localparam int GB_START = 1;
   localparam int GB_GMODE = 2;
   localparam int GB_WDOG = 3;
   localparam int LS_UNIT2 = 2;
   // interrupt and status bits
   localparam int IRQ_UNDER = 0;
   localparam int IRQ_RELOAD = 1;
   localparam int IRQ_W = 2;
   localparam int ST_MODE = 0;
   localparam int ST_PULSE = 1;
   localparam int ST_RUN = 2;
   // widths and reset values
   localparam int CNT_W = 16;
   localparam int REG_W = 8;
   localparam int PRE_W = 8;
   localparam logic [7:0] GLOBAL_RST = 8'h00;
   localparam logic [7:0] CMD_RST = 8'h00;
   localparam logic [15:0] IMAGE_RST = 16'h0000;
   localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
   // timer clock prescaling
   localparam int SCALE_SLOW = 8;
   localparam int SCALE_FAST = 1;
   localparam int BASE_DIV = 4;
   localparam int HTRANS_BUSY_BIT = 1;
   // unit-two watchdog states
   typedef enum logic [1:0] {
      WD_OFF = 2'b00,
      WD_COUNT = 2'b01,
      WD_PULSE = 2'b10
   } twd_state_type;
endpackage : twd_pkg

//--- common/twd_if.sv
// link between register front end and unit-two counter core
`timescale 1ns/1ps
`default_nettype none
interface twd_if;
   import twd_pkg::*;
   logic run;
   logic scale;
   logic reload;
   logic cnt_wr;
   logic [CNT_W-1:0] cnt_wdata;
   logic [CNT_W-1:0] image;
   logic [CNT_W-1:0] count;
   logic pulse;
   logic underflow;
   logic active;
   modport ctl (output run, scale, reload, cnt_wr, cnt_wdata, image,
                input count, pulse, underflow, active);
   modport unit (input run, scale, reload, cnt_wr, cnt_wdata, image,
                 output count, pulse, underflow, active);
endinterface : twd_if
`default_nettype wire

//--- hw/twd_unit.sv
// unit-two down counter with prescaler and pulse generator
`timescale 1ns/1ps
`default_nettype none
module twd_unit #(
   parameter int BASE = twd_pkg::BASE_DIV
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   twd_if.unit u
);
   import twd_pkg::*;

   typedef struct packed {
      twd_state_type mode;
      logic [CNT_W-1:0] count;
      logic [CNT_W-1:0] width;
      logic [PRE_W-1:0] presc;
      logic underflow;
   } twd_unit_type;

   twd_unit_type s_ff, nxt_s;
   logic tick;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.underflow = 1'b0;
      tick = 1'b0;
      // timer clock: base divide, then the scale stage
      if (u.run) begin
         if (s_ff.presc == '0) begin
            tick = 1'b1;
            nxt_s.presc = u.scale ? PRE_W'(BASE * SCALE_SLOW - 1)
                                  : PRE_W'(BASE * SCALE_FAST - 1);
         end else begin
            nxt_s.presc = s_ff.presc - 1'b1;
         end
      end else begin
         nxt_s.presc = '0;
      end
      case (s_ff.mode)
         WD_OFF: begin
            if (u.cnt_wr) begin
               nxt_s.count = u.cnt_wdata;
            end
            if (u.reload) begin
               nxt_s.count = u.image;
            end
            if (u.run) begin
               nxt_s.mode = WD_COUNT;
            end
         end
         WD_COUNT: begin
            if (u.reload) begin
               nxt_s.count = u.image;
            end else if (tick) begin
               if (s_ff.count == '0) begin
                  nxt_s.underflow = 1'b1;
                  nxt_s.count = u.image;
                  if (u.image != '0) begin
                     nxt_s.mode = WD_PULSE;
                     nxt_s.width = u.image;
                  end
               end else begin
                  nxt_s.count = s_ff.count - 1'b1;
               end
            end
         end
         WD_PULSE: begin
            // a strobe during the pulse rearms but cannot cut it short
            if (u.reload) begin
               nxt_s.count = u.image;
            end
            if (tick) begin
               nxt_s.width = s_ff.width - 1'b1;
               if (s_ff.width == CNT_W'(1)) begin
                  nxt_s.mode = WD_COUNT;
               end
            end
         end
         default: begin
            nxt_s.mode = WD_OFF;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_ff <= '{mode: WD_OFF, default: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign u.count = s_ff.count;
   assign u.pulse = (s_ff.mode == WD_PULSE);
   assign u.underflow = s_ff.underflow;
   assign u.active = (s_ff.mode != WD_OFF);
endmodule : twd_unit
`default_nettype wire

//--- bench/twd_chk.sv
// port-level assertion checker for the unit-two watchdog top
`timescale 1ns/1ps
`default_nettype none
module twd_chk
   import twd_pkg::*;
#(
   parameter int BASE = 4
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic watchdog_pulse_internal_o,
   input wire logic irq_o
);
   logic dph_ff, wr_ff, mode_ff, run_ff, scl_ff, msk_ff;
   logic [7:0] adr_ff;
   logic [7:0] cmd_ff;
   logic [15:0] img_ff;
   logic [31:0] pw_ff;
   logic rd_end;
   logic wr_end;
   // a data phase ends at the edge where ready comes back
   assign rd_end = dph_ff & hreadyout_o & ~wr_ff;
   assign wr_end = dph_ff & hreadyout_o & wr_ff;
   // shadow of what software set before the lock, and pulse length
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         {dph_ff, wr_ff, mode_ff, run_ff, scl_ff, msk_ff} <= 6'h00;
         adr_ff <= 8'h00;
         cmd_ff <= 8'h00;
         img_ff <= 16'h0000;
         pw_ff <= 32'h0;
      end else begin
         if (hreadyout_o) begin
            dph_ff <= hsel_i & htrans_i[1] & hready_i;
            wr_ff <= hwrite_i;
            adr_ff <= haddr_i[7:0];
         end
         if (wr_end && !mode_ff && adr_ff == OFS_GLOBAL) begin
            mode_ff <= hwdata_i[GB_WDOG];
            run_ff <= hwdata_i[GB_WDOG] & hwdata_i[GB_START];
            scl_ff <= hwdata_i[GB_SCALE];
         end
         if (wr_end && !mode_ff && adr_ff == OFS_IMAGE)
            img_ff <= hwdata_i[15:0];
         if (wr_end && !mode_ff && adr_ff == OFS_CMD)
            cmd_ff <= hwdata_i[7:0];
         if (wr_end && adr_ff == OFS_IMASK)
            msk_ff <= hwdata_i[IRQ_UNDER];
         pw_ff <= watchdog_pulse_internal_o ? pw_ff + 32'h1 : 32'h0;
      end
   end
   default clocking dc @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);
   property p_idle;
      !run_ff |-> !watchdog_pulse_internal_o;
   endproperty
   a_idle: assert property (p_idle)
      else $error("pulse while not running");
   property p_width;
      $fell(watchdog_pulse_internal_o) |->
         pw_ff == img_ff * BASE * (scl_ff ? SCALE_SLOW : SCALE_FAST);
   endproperty
   a_width: assert property (p_width)
      else $error("pulse width off");
   property p_glob;
      rd_end && adr_ff == OFS_GLOBAL && mode_ff |-> hrdata_o[GB_WDOG]
         && hrdata_o[GB_START] == run_ff && hrdata_o[GB_SCALE] == scl_ff;
   endproperty
   a_glob: assert property (p_glob)
      else $error("global bits changed in lock");
   property p_img;
      rd_end && adr_ff == OFS_IMAGE && mode_ff |-> hrdata_o[15:0] == img_ff;
   endproperty
   a_img: assert property (p_img)
      else $error("image changed in lock");
   property p_cmd;
      rd_end && adr_ff == OFS_CMD && mode_ff |-> hrdata_o[7:0] == cmd_ff;
   endproperty
   a_cmd: assert property (p_cmd)
      else $error("unit command changed in lock");
   property p_mode;
      rd_end && adr_ff == OFS_STATUS |-> hrdata_o[ST_MODE] == mode_ff;
   endproperty
   a_mode: assert property (p_mode)
      else $error("mode flag wrong");
   property p_run;
      rd_end && adr_ff == OFS_STATUS && mode_ff |-> hrdata_o[ST_RUN] == run_ff;
   endproperty
   a_run: assert property (p_run)
      else $error("run flag wrong");
   property p_irq;
      msk_ff && $rose(watchdog_pulse_internal_o) |-> ##[0:2] irq_o;
   endproperty
   a_irq: assert property (p_irq)
      else $error("no interrupt on underflow");
   // refused writes give no sign: every response stays okay
   property p_okay;
      hreadyout_o |-> !hresp_o;
   endproperty
   a_okay: assert property (p_okay)
      else $error("error response seen");
endmodule : twd_chk
`default_nettype wire

//--- bench/twd_host.sv
// bus master model standing for the host processor
`timescale 1ns/1ps
`default_nettype none
module twd_host (
   input wire logic clk_sys_i,
   input wire logic hready_i,
   output logic hsel_o,
   output logic [31:0] haddr_o,
   output logic [1:0] htrans_o,
   output logic hwrite_o,
   output logic [2:0] hsize_o,
   output logic [31:0] hwdata_o,
   output logic fault_o
);
   // idle bus from time zero
   initial begin
      hsel_o = 1'b0;
      haddr_o = 32'h0;
      htrans_o = 2'h0;
      hwrite_o = 1'b0;
      hsize_o = 3'h2;
      hwdata_o = 32'h0;
      fault_o = 1'b0;
   end
   // ready is sampled at rising edges; a stuck slave raises fault
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (hready_i !== 1'b1 && n < 64);
      if (hready_i !== 1'b1)
         fault_o <= 1'b1;
   endtask : wait_rdy
   // one single word transfer, address phase then data phase
   task automatic xfer(input logic wr, input logic [7:0] adr,
         input logic [31:0] dat);
      hsel_o <= 1'b1;
      haddr_o <= {24'h000000, adr};
      htrans_o <= 2'h2;
      hwrite_o <= wr;
      hwdata_o <= ~hwdata_o; // stale data scrambled, never reusable
      wait_rdy();
      hsel_o <= 1'b0;
      htrans_o <= 2'h0;
      hwdata_o <= dat;
      wait_rdy();
   endtask : xfer
endmodule : twd_host
`default_nettype wire

//--- bench/test_timer_two_watchdog.sv
// self-checking bench for the unit-two watchdog
`timescale 1ns/1ps
`default_nettype none
module test_timer_two_watchdog;
   import twd_pkg::*;
   localparam int B = 4;
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, pulse, irq, fault;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [32:0] q_rd[$];
   logic [31:0] q_pw[$];
   logic rd_ph = 1'b0;
   logic kick = 1'b0;
   logic [31:0] pw = 32'h0;
   logic [15:0] img;
   int err_count = 0;
   int checks = 0;
   always #12.5 clk_sys_i = ~clk_sys_i;
   twd_top #(.BASE(B)) DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
      .hresp_o(hresp), .watchdog_pulse_internal_o(pulse), .irq_o(irq));
   twd_host u_host (.clk_sys_i(clk_sys_i), .hready_i(hreadyout),
      .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
      .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata),
      .fault_o(fault));
   task automatic wrap_up;
      if (q_rd.size() != 0 || q_pw.size() != 0)
         err_count++;
      if (err_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   task automatic cmp_rd(input logic [32:0] got);
      logic [32:0] exp;
      exp = (q_rd.size() > 0) ? q_rd.pop_front() : {33{1'bz}};
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask : cmp_rd
   task automatic cmp_pw(input logic [31:0] got);
      logic [31:0] exp;
      exp = (q_pw.size() > 0) ? q_pw.pop_front() : {32{1'bz}};
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask : cmp_pw
   // watcher: read data with irq, and every pulse length
   always @(posedge clk_sys_i) begin
      if (rd_ph && hreadyout)
         cmp_rd({irq, hrdata});
      if (hreadyout)
         rd_ph = hsel && htrans[1] && !hwrite;
      if (pulse)
         pw = pw + 32'h1;
      else if (pw != 32'h0) begin
         cmp_pw(pw);
         pw = 32'h0;
      end
   end
   // a hung slave ends the run
   always @(posedge fault) begin
      err_count++;
      wrap_up();
   end
   // while kick is set every access is followed by a reload strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d);
      if (kick)
         u_host.xfer(1'b1, OFS_LOADST, 32'h4);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      q_rd.push_back(e);
      u_host.xfer(1'b0, a, 32'h0);
      if (kick)
         u_host.xfer(1'b1, OFS_LOADST, 32'h4);
   endtask : rd
   task automatic wait_lvl(input logic v, input int n);
      while (pulse !== v && n > 0) begin
         @(posedge clk_sys_i);
         n--;
      end
      if (pulse !== v) begin
         err_count++;
         wrap_up();
      end
   endtask : wait_lvl
   task automatic do_reset;
      resetn_i <= 1'b0;
      repeat (20) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
   endtask : do_reset
   // main sequence: reset values, lock, suppression, scaled pulse
   initial begin
      void'($urandom(10260));
      do_reset();
      for (int i = 0; i < 9; i++)
         rd(8'(4 * i), 33'h0);
      wr(OFS_COUNT, 32'h7);
      wr(OFS_IMAGE, 32'h8);
      wr(OFS_CMD, 32'h5A);
      wr(OFS_LOADST, 32'h4);
      rd(OFS_COUNT, 33'h8);
      q_pw.push_back(32'h8 * B);
      wr(OFS_GLOBAL, 32'hE);
      wait_lvl(1'b1, 200);
      wr(OFS_LOADST, 32'h4);
      rd(OFS_STATUS, 33'h7);
      wr(OFS_LOADST, 32'h4);
      wait_lvl(1'b0, 200);
      kick = 1'b1;
      wr(OFS_LOADST, 32'h4);
      rd(OFS_GLOBAL, 33'hE);
      wr(OFS_GLOBAL, 32'h0);
      rd(OFS_GLOBAL, 33'hA);
      wr(OFS_IMAGE, 32'h3);
      rd(OFS_IMAGE, 33'h8);
      wr(OFS_CMD, 32'hFF);
      rd(OFS_CMD, 33'h5A);
      rd(OFS_STATUS, 33'h5);
      rd(OFS_ISTAT, 33'h3);
      wr(OFS_IMASK, 32'h1);
      rd(OFS_ISTAT, 33'h1_0000_0003);
      wr(OFS_ISTAT, 32'h1);
      rd(OFS_ISTAT, 33'h2);
      kick = 1'b0;
      do_reset();
      img = 16'(1 + $urandom % 3);
      wr(OFS_IMAGE, {16'h0000, img});
      wr(OFS_IMASK, 32'h1);
      wr(OFS_LOADST, 32'h4);
      q_pw.push_back(img * B * SCALE_SLOW);
      wr(OFS_GLOBAL, 32'hB);
      wait_lvl(1'b1, 600);
      wait_lvl(1'b0, 600);
      @(posedge clk_sys_i);
      wrap_up();
   end
endmodule : test_timer_two_watchdog
bind twd_top twd_chk #(.BASE(BASE)) u_chk (.clk_sys_i(clk_sys_i),
   .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
   .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .watchdog_pulse_internal_o(watchdog_pulse_internal_o), .irq_o(irq_o));
`default_nettype wire
